/* afbp_pkg.sv */
// Shared constants and types for the strobe-driven parallel port
package afbp_pkg;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  // Pin mode selected by the host command
  typedef enum logic [1:0] {AFBP_MODE_OFF, AFBP_MODE_FIFO, AFBP_MODE_BITBANG} afbp_mode_t;
  localparam logic [1:0] CMD_MODE_OFF = 2'h0;
  localparam logic [1:0] CMD_MODE_FIFO = 2'h1;
  localparam logic [1:0] CMD_MODE_BITBANG = 2'h2;
  // Strobe output pulse width in nanoseconds, rounded up to clock cycles
  localparam int STROBE_NS = 10;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
endpackage : afbp_pkg

/* afbp_buf2.sv */
// Two-entry buffer with valid and ready on both sides
module afbp_buf2 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [afbp_pkg::DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [afbp_pkg::DATA_W-1:0] out_data
);
  logic [afbp_pkg::DATA_W-1:0] mem_reg [afbp_pkg::BUF_DEPTH];
  logic wptr_reg;
  logic rptr_reg;
  logic [1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Flags from the fill count
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rptr_reg];

  // Pointer and count update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (ce) begin
      if (flush) begin
        wptr_reg <= 1'b0;
        rptr_reg <= 1'b0;
        count_reg <= 2'h0;
      end else begin
        if (push) wptr_reg <= ~wptr_reg;
        if (pop) rptr_reg <= ~rptr_reg;
        count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
      end
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (ce && push) mem_reg[wptr_reg] <= in_data;
  end
endmodule : afbp_buf2

/* afbp_port.sv */
// Parallel port: asynchronous FIFO mode and bit-bang mode on one 8-bit bus
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - FIFO pin behaviour only when configuration memory selects async FIFO mode.
// - Falling edges of read and write strobes perform the transfers.
// - In FIFO mode the data bus is input; driven only while read strobe is low.
// - Data-available flag low when a receive byte waits; controller reads only then.
// - Read strobe rising drops data-available; reasserts only if another byte waits.
// - During reset both flags are undriven and read as high.
// - Space-available low when transmit side accepts; controller writes only then.
// - Byte shown on read strobe fall; next byte fetched on its rise.
// - Bus captured into transmit path on write strobe falling edge.
// - Wake pulse while suspended with wakeup enabled requests resume.
// - Wake pulse while active requests that transmit data be sent on next Bulk-IN.
// - Bit-bang mode makes the eight lines one bidirectional parallel bus.
// - Bit-bang mode entered only by the host pin-mode command.
// - Bit-bang pulses write-indicate low after new host data reaches pins.
// - Bit-bang raises read-indicate after pins are sampled and sent.
module afbp_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic cfg_async_fifo,
  input wire logic cfg_remote_wake,
  input wire logic set_pin_mode_valid,
  input wire logic [1:0] set_pin_mode_command,
  input wire logic usb_configured_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic send_now_wake_n,
  input wire logic [7:0] parallel_data_bus_in,
  output logic [7:0] parallel_data_bus_out,
  output logic [7:0] parallel_data_bus_oe,
  output logic rx_data_avail_n,
  output logic rx_data_avail_oe,
  output logic tx_space_avail_n,
  output logic tx_space_avail_oe,
  output logic pins_updated_strobe_n,
  output logic pins_sampled_strobe,
  input wire logic host_rx_valid,
  output logic host_rx_ready,
  input wire logic [7:0] host_rx_data,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  output logic [7:0] host_tx_data,
  input wire logic [7:0] bb_dir,
  output logic resume_req,
  output logic send_now_req
);
  afbp_pkg::afbp_mode_t mode_reg;
  afbp_pkg::afbp_mode_t mode_next;
  logic rd_d_reg;
  logic wr_d_reg;
  logic wake_d_reg;
  logic [7:0] rx_hold_reg;
  logic rx_hold_valid_reg;
  logic rx_show_reg;
  logic rxf_n_reg;
  logic txe_n_reg;
  logic [7:0] bus_out_reg;
  logic [7:0] bus_oe_reg;
  logic upd_n_reg;
  logic smp_reg;
  logic [3:0] upd_cnt_reg;
  logic [3:0] smp_cnt_reg;
  logic resume_reg;
  logic send_now_reg;
  logic flags_oe_reg;
  logic bb_sample_reg;
  logic tx_wait_reg;
  logic rxb_out_valid;
  logic rxb_out_ready;
  logic [7:0] rxb_out_data;
  logic txb_in_ready;
  logic txb_in_valid;
  logic [7:0] txb_in_data;
  logic host_tx_valid_w;
  logic [7:0] host_tx_data_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and strobe edge decode
  wire fifo_mode = (mode_reg == afbp_pkg::AFBP_MODE_FIFO);
  wire bb_mode = (mode_reg == afbp_pkg::AFBP_MODE_BITBANG);
  // Strobe history resets to the idle high level: no false edge after reset
  wire rd_fall = rd_d_reg && !rd_n;
  wire rd_rise = !rd_d_reg && rd_n;
  wire wr_fall = wr_d_reg && !wr_n;
  // Wake counts on the rising end of its low strobe
  wire wake_pulse = !wake_d_reg && send_now_wake_n;
  // Reads with the data flag high and writes with the space flag high are ignored
  wire rd_ok = fifo_mode && rd_fall && !rxf_n_reg;
  wire wr_ok = fifo_mode && wr_fall && !txe_n_reg;
  // The update strobe generator is idle when high and counted out
  wire upd_busy = upd_cnt_reg != 4'h0;
  wire smp_busy = smp_cnt_reg != 4'h0;
  wire upd_idle = upd_n_reg && !upd_busy;
  // A new host byte goes to the pins only while the update strobe is idle
  wire bb_write = bb_mode && rxb_out_valid && upd_idle;
  wire bb_send = bb_mode && bb_sample_reg && txb_in_ready;
  // Sampling runs whenever the sample strobe is idle, so the host sees
  // a steady stream of pin values
  wire bb_sample_next = bb_mode && !bb_sample_reg && !smp_busy;
  // Counters load one less: the load edge is already the first strobe cycle
  wire [3:0] strobe_reload = afbp_pkg::STROBE_CNT - 4'h1;
  wire mode_cmd_fifo = set_pin_mode_command == afbp_pkg::CMD_MODE_FIFO;
  wire mode_cmd_bb = set_pin_mode_command == afbp_pkg::CMD_MODE_BITBANG;

  // Next mode from host command; FIFO needs the config strap
  always_comb begin
    mode_next = mode_reg;
    if (set_pin_mode_valid) begin
      if (mode_cmd_bb) mode_next = afbp_pkg::AFBP_MODE_BITBANG;
      else if (mode_cmd_fifo && cfg_async_fifo) mode_next = afbp_pkg::AFBP_MODE_FIFO;
      else mode_next = afbp_pkg::AFBP_MODE_OFF;
    end
    // Losing the strap drops FIFO mode at once; bit-bang needs no strap
    if (!cfg_async_fifo && mode_reg == afbp_pkg::AFBP_MODE_FIFO) begin
      mode_next = afbp_pkg::AFBP_MODE_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive buffer: host to pins
  // Two entries plus the hold register let the host run ahead of the reads
  assign rxb_out_ready = (fifo_mode && !rx_hold_valid_reg) || bb_write;

  afbp_buf2 u_rx_buf (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .flush(1'b0),
    .in_valid(host_rx_valid),
    .in_ready(host_rx_ready),
    .in_data(host_rx_data),
    .out_valid(rxb_out_valid),
    .out_ready(rxb_out_ready),
    .out_data(rxb_out_data)
  );

  // Transmit buffer: pins to host
  // A full buffer keeps the space flag high rather than dropping a byte
  assign txb_in_valid = wr_ok || bb_send;
  assign txb_in_data = parallel_data_bus_in;

  afbp_buf2 u_tx_buf (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .flush(1'b0),
    .in_valid(txb_in_valid),
    .in_ready(txb_in_ready),
    .in_data(txb_in_data),
    .out_valid(host_tx_valid_w),
    .out_ready(host_tx_ready),
    .out_data(host_tx_data_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode, strobe history and wake
  // Resume and send requests are one-cycle pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= afbp_pkg::AFBP_MODE_OFF;
      rd_d_reg <= 1'b1;
      wr_d_reg <= 1'b1;
      wake_d_reg <= 1'b1;
      flags_oe_reg <= 1'b0;
      resume_reg <= 1'b0;
      send_now_reg <= 1'b0;
    end else if (ce) begin
      mode_reg <= mode_next;
      rd_d_reg <= rd_n;
      wr_d_reg <= wr_n;
      wake_d_reg <= send_now_wake_n;
      flags_oe_reg <= fifo_mode;
      resume_reg <= wake_pulse && usb_configured_n && cfg_remote_wake;
      send_now_reg <= wake_pulse && !usb_configured_n;
    end
  end

  // Hold register fill from the buffer and release after a read
  wire hold_load = fifo_mode && !rx_hold_valid_reg && rxb_out_valid;
  wire hold_drop = rd_rise && rx_show_reg;
  // Flag rises on every read release; falls only once a fresh byte is held
  // and the strobe is back high, so one read never sees two flag lows
  wire rxf_clr = rd_rise || !fifo_mode;
  wire rxf_set = rx_hold_valid_reg && rd_n && !rx_show_reg;

  // Held receive byte and data-available flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_hold_reg <= afbp_pkg::DATA_RESET;
      rx_hold_valid_reg <= 1'b0;
      rx_show_reg <= 1'b0;
      rxf_n_reg <= 1'b1;
    end else if (ce) begin
      if (hold_load) begin
        rx_hold_reg <= rxb_out_data;
        rx_hold_valid_reg <= 1'b1;
      end else if (hold_drop) begin
        rx_hold_valid_reg <= 1'b0;
      end
      if (rd_ok) rx_show_reg <= 1'b1;
      else if (rd_rise) rx_show_reg <= 1'b0;
      if (rxf_clr) rxf_n_reg <= 1'b1;
      else if (rxf_set) rxf_n_reg <= 1'b0;
    end
  end

  // Space flag drops on every accepted write and stays up until the
  // strobe is released, so a held-low strobe cannot reopen the flag
  wire txe_clr = !fifo_mode || wr_ok;
  wire tx_wait_end = tx_wait_reg && wr_n;
  wire txe_set = !tx_wait_reg && txb_in_ready && !wr_fall;

  // Space-available flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txe_n_reg <= 1'b1;
      tx_wait_reg <= 1'b0;
    end else if (ce) begin
      if (txe_clr) begin
        txe_n_reg <= 1'b1;
        tx_wait_reg <= wr_ok;
      end else if (tx_wait_end) begin
        tx_wait_reg <= 1'b0;
      end else if (txe_set) begin
        txe_n_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read drive: only while the strobe is low after an accepted fall
  wire rd_drive = fifo_mode && !rd_n && (rx_show_reg || rd_ok);
  logic [7:0] bus_out_next;
  logic [7:0] bus_oe_next;

  // Per-line select: held byte in FIFO mode, host byte and mask in bit-bang
  for (genvar i = 0; i < afbp_pkg::DATA_W; i++) begin : g_line
    assign bus_out_next[i] = fifo_mode ? rx_hold_reg[i] :
      (bb_write ? rxb_out_data[i] : bus_out_reg[i]);
    assign bus_oe_next[i] = fifo_mode ? rd_drive : (bb_mode && bb_dir[i]);
  end

  // Data bus drive registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_out_reg <= afbp_pkg::DATA_RESET;
      bus_oe_reg <= 8'h00;
    end else if (ce) begin
      bus_out_reg <= bus_out_next;
      bus_oe_reg <= bus_oe_next;
    end
  end

  // Bit-bang indicate strobes
  // Update strobe low after each host byte; sample strobe rises per sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upd_n_reg <= 1'b1;
      upd_cnt_reg <= 4'h0;
      smp_reg <= 1'b1;
      smp_cnt_reg <= 4'h0;
      bb_sample_reg <= 1'b0;
    end else if (ce) begin
      if (bb_write) begin
        upd_n_reg <= 1'b0;
        upd_cnt_reg <= strobe_reload;
      end else if (upd_busy) begin
        upd_cnt_reg <= upd_cnt_reg - 4'h1;
      end else begin
        upd_n_reg <= 1'b1;
      end
      bb_sample_reg <= bb_sample_next;
      if (bb_send) begin
        smp_reg <= 1'b1;
        smp_cnt_reg <= strobe_reload;
      end else if (smp_busy) begin
        smp_cnt_reg <= smp_cnt_reg - 4'h1;
      end else if (bb_mode) begin
        smp_reg <= 1'b0;
      end
    end
  end

  // Output pins
  // Flag enables stay low outside FIFO mode, so the pull-ups hold them high
  assign parallel_data_bus_out = bus_out_reg;
  assign parallel_data_bus_oe = bus_oe_reg;
  assign rx_data_avail_n = rxf_n_reg;
  assign rx_data_avail_oe = flags_oe_reg;
  assign tx_space_avail_n = txe_n_reg;
  assign tx_space_avail_oe = flags_oe_reg;
  assign pins_updated_strobe_n = upd_n_reg;
  assign pins_sampled_strobe = smp_reg;
  assign resume_req = resume_reg;
  assign send_now_req = send_now_reg;
  assign host_tx_valid = host_tx_valid_w;
  assign host_tx_data = host_tx_data_w;
endmodule : afbp_port

/* afbp_port_asserts.sv */
// Checker for the port: flag timing, bus turnaround, strobes, wake pulses
module afbp_port_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cfg_async_fifo,
  input wire logic cfg_remote_wake,
  input wire logic set_pin_mode_valid,
  input wire logic [1:0] set_pin_mode_command,
  input wire logic usb_configured_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] parallel_data_bus_oe,
  input wire logic rx_data_avail_n,
  input wire logic rx_data_avail_oe,
  input wire logic tx_space_avail_n,
  input wire logic tx_space_avail_oe,
  input wire logic pins_updated_strobe_n,
  input wire logic resume_req,
  input wire logic send_now_req
);
  logic fifo_reg;
  logic bb_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Mode as selected by the host command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo_reg <= 1'b0;
      bb_reg <= 1'b0;
    end else if (set_pin_mode_valid) begin
      fifo_reg <= cfg_async_fifo && set_pin_mode_command == afbp_pkg::CMD_MODE_FIFO;
      bb_reg <= set_pin_mode_command == afbp_pkg::CMD_MODE_BITBANG;
    end
  end
  ////////////////////////////////////////
  chk_bus_off_mode: assert property (!fifo_reg && !bb_reg |-> parallel_data_bus_oe == 8'h00)
    else $error("bus driven with no mode");
  chk_bus_turn_on: assert property (fifo_reg && $fell(rd_n) && !rx_data_avail_n |=>
    parallel_data_bus_oe == 8'hFF) else $error("bus not driven after read fall");
  chk_bus_release: assert property (fifo_reg && $rose(rd_n) |=> parallel_data_bus_oe == 8'h00)
    else $error("bus held after read rise");
  chk_rx_flag_drop: assert property (fifo_reg && $rose(rd_n) |=> rx_data_avail_n)
    else $error("data flag low after read rise");
  chk_tx_flag_drop: assert property (fifo_reg && $fell(wr_n) && !tx_space_avail_n |=>
    tx_space_avail_n) else $error("space flag low after write");
  chk_flags_reset: assert property ($rose(nrst) |-> rx_data_avail_n && tx_space_avail_n &&
    !rx_data_avail_oe && !tx_space_avail_oe) else $error("flags driven from reset");
  chk_upd_width: assert property ($fell(pins_updated_strobe_n) |=>
    !pins_updated_strobe_n ##1 pins_updated_strobe_n) else $error("update strobe width");
  chk_resume_pulse: assert property (resume_req |-> usb_configured_n && cfg_remote_wake
    ##1 !resume_req) else $error("resume request out of place");
  chk_send_pulse: assert property (send_now_req |-> !usb_configured_n ##1 !send_now_req)
    else $error("send request out of place");
  cover property (fifo_reg && $fell(rd_n));
  cover property (fifo_reg && $fell(wr_n));
  cover property ($fell(pins_updated_strobe_n));
endmodule : afbp_port_chk

bind afbp_port afbp_port_chk u_chk (.*);

/* afbp_ctrl_model.sv */
// Controller model: read and write strobes and its side of the data bus
module afbp_ctrl_model (
  input wire logic clk,
  input wire logic rx_data_avail_n,
  input wire logic tx_space_avail_n,
  input wire logic [7:0] parallel_data_bus_out,
  input wire logic [7:0] parallel_data_bus_oe,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] parallel_data_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] last_reg = 8'h00;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // Released lines show the inverse of their last level
  always_comb parallel_data_bus_in = (parallel_data_bus_oe & parallel_data_bus_out) |
    (~parallel_data_bus_oe & (drv ? val : ~last_reg));
  always @(posedge clk) last_reg <= parallel_data_bus_in;
  // Read one byte, strobe low for hold+2 cycles
  task automatic rd(output logic [7:0] d, input int hold);
    do @(negedge clk); while (rx_data_avail_n !== 1'b0);
    @(posedge clk);
    rd_n <= 1'b0;
    repeat (hold + 1) @(posedge clk);
    @(negedge clk);
    d = parallel_data_bus_in;
    @(posedge clk);
    rd_n <= 1'b1;
    // Let the flag drop be seen before the next read looks at it
    @(posedge clk);
  endtask : rd
  // Write one byte, data settled before the strobe falls
  task automatic wr(input logic [7:0] d, input int hold);
    do @(negedge clk); while (tx_space_avail_n !== 1'b0);
    @(posedge clk);
    drv <= 1'b1;
    val <= d;
    @(posedge clk);
    wr_n <= 1'b0;
    repeat (hold + 1) @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    drv <= 1'b0;
  endtask : wr
endmodule : afbp_ctrl_model

/* testbench.sv */
// Self-checking bench for the parallel port in FIFO and bit-bang modes
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, cfg_async_fifo = 1'b1, cfg_remote_wake = 1'b1;
  logic set_pin_mode_valid = 1'b0, usb_configured_n = 1'b0, send_now_wake_n = 1'b1;
  logic host_rx_valid = 1'b0, host_tx_ready = 1'b0, acc;
  logic [1:0] set_pin_mode_command = 2'h0;
  logic [7:0] host_rx_data = 8'h00, bb_dir = 8'h00, w, got;
  logic [7:0] parallel_data_bus_in, parallel_data_bus_out, parallel_data_bus_oe, host_tx_data;
  logic rd_n, wr_n, rx_data_avail_n, rx_data_avail_oe, tx_space_avail_n, tx_space_avail_oe;
  logic pins_updated_strobe_n, pins_sampled_strobe, host_rx_ready, host_tx_valid;
  logic resume_req, send_now_req;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 32'h43A6, n_res, n_snd, n_smp;
  logic [7:0] q[$];
  afbp_port DUT (.*);
  afbp_ctrl_model u_ctl (.*);
  initial forever #2.5 clk = ~clk;
  // Cycle ceiling and pulse counters
  always @(posedge clk) begin
    cyc++;
    if (resume_req === 1'b1) n_res++;
    if (send_now_req === 1'b1) n_snd++;
    if ($rose(pins_sampled_strobe)) n_smp++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    set_pin_mode_command <= m;
    set_pin_mode_valid <= 1'b1;
    @(posedge clk);
    set_pin_mode_valid <= 1'b0;
  endtask : set_mode
  // Main sequence
  initial begin
    @(posedge clk);
    @(negedge clk);
    chk({4'h0, rx_data_avail_oe, tx_space_avail_oe, rx_data_avail_n, tx_space_avail_n}, 8'h03);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(negedge clk);
    chk({6'h00, rx_data_avail_n, tx_space_avail_n}, 8'h03);
    set_mode(afbp_pkg::CMD_MODE_FIFO);
    host_rx_data <= 8'($random(seed));
    host_rx_valid <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      acc = host_rx_ready;
      if (acc === 1'b1) q.push_back(host_rx_data);
      @(posedge clk);
      if (acc === 1'b1) host_rx_data <= 8'($random(seed));
    end
    host_rx_valid <= 1'b0;
    chk({7'h00, acc}, 8'h00);
    while (q.size() > 0) begin
      u_ctl.rd(got, $unsigned($random(seed)) % 3);
      chk(got, q.pop_front());
    end
    repeat (4) @(negedge clk);
    chk({rx_data_avail_n, parallel_data_bus_oe[6:0]}, 8'h80);
    for (int i = 0; i < 6; i++) begin
      repeat (8) @(negedge clk);
      if (tx_space_avail_n !== 1'b0) break;
      w = 8'($random(seed));
      q.push_back(w);
      u_ctl.wr(w, i % 3);
    end
    chk({7'h00, tx_space_avail_n}, 8'h01);
    @(posedge clk);
    host_tx_ready <= 1'b1;
    while (q.size() > 0) begin
      @(negedge clk);
      if (host_tx_valid === 1'b1) chk(host_tx_data, q.pop_front());
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      cfg_remote_wake <= (i != 2);
      usb_configured_n <= (i != 0);
      n_res = 0;
      n_snd = 0;
      @(posedge clk);
      send_now_wake_n <= 1'b0;
      repeat (2) @(posedge clk);
      send_now_wake_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk({7'h00, n_res != 0}, {7'h00, i == 1});
      chk({7'h00, n_snd != 0}, {7'h00, i == 0});
    end
    set_mode(afbp_pkg::CMD_MODE_BITBANG);
    w = 8'($random(seed));
    bb_dir <= 8'hFF;
    host_rx_data <= w;
    host_rx_valid <= 1'b1;
    do @(negedge clk); while (host_rx_ready !== 1'b1);
    @(posedge clk);
    host_rx_valid <= 1'b0;
    do @(negedge clk); while (pins_updated_strobe_n !== 1'b0);
    chk(parallel_data_bus_out & parallel_data_bus_oe, w);
    @(posedge clk);
    bb_dir <= 8'h00;
    u_ctl.val <= ~w;
    u_ctl.drv <= 1'b1;
    n_smp = 0;
    repeat (20) @(posedge clk);
    do @(negedge clk); while (host_tx_valid !== 1'b1);
    chk(host_tx_data, ~w);
    chk({7'h00, n_smp != 0}, 8'h01);
    // Clock enable low freezes the sample strobe
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    n_smp = 0;
    repeat (10) @(posedge clk);
    chk({7'h00, n_smp != 0}, 8'h00);
    ce <= 1'b1;
    test_done();
  end
endmodule : testbench
